// >>> src/pio_panel_top.sv
// Panel general functions: fault recall, jog, forced outputs, diagnosis
// Contract
// - Set on a selected fault-record parameter shows that stored record
// - Set on jog parameter shows jog speed, default 20 r/min
// - Up and down adjust jog speed while it is shown
// - Second set shows jog indication and enters jog mode
// - In jog, held up runs forward, down reverse; release stops
// - Jog motion only while servo on
// - Writing 406 to special function parameter enters forced output
// - Force mask is binary, bit n-1 drives output n
// - Forced state not kept; reset or writing 400 ends it
// - Force mask shown in hex, fifth digit blank
// - Input diagnosis shows inputs one to nine by bit
// - Output diagnosis shows outputs one to six by bit in hex
// - Hex values on the panel leave the leftmost digit blank
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pio_params.svh"

module pio_panel_top #(
	parameter logic [15:0] JOG_MAX = `PIO_JOG_SPD_MAX
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        key_set,
	input  wire logic        key_up,
	input  wire logic        key_down,
	input  wire logic        key_mode,
	input  wire logic        servo_on,
	input  wire logic        fault_log,
	input  wire logic [15:0] fault_code,
	input  wire logic [8:0]  digital_input_lines,
	input  wire logic [5:0]  do_func,
	output logic      [5:0]  digital_output_lines,
	output logic             jog_fwd,
	output logic             jog_rev,
	output logic      [15:0] jog_speed,
	output logic      [24:0] disp_digits,
	output logic             irq
);

	pio_pkg::pio_view_t view_r;
	pio_pkg::pio_view_t view_nxt;
	logic [3:0]  press;
	logic        set_p;
	logic        up_p;
	logic        down_p;
	logic        mode_p;
	logic [3:0]  psel_r;
	logic [15:0] sfunc_r;
	logic        force_r;
	logic [5:0]  fmask_r;
	logic [15:0] jog_spd_r;
	logic [3:0]  istat_r;
	logic [3:0]  imask_r;
	logic [3:0]  ev;
	logic [3:0]  istat_nxt;
	logic [15:0] fault_rd;
	logic [15:0] hexval;
	logic [24:0] disp_nxt;
	logic [31:0] rd_nxt;
	logic        rd_hit;
	logic        acc;
	logic        wr;
	logic        rd_stat;

	pio_key_edge #(
		.WIDTH(4)
	) u_keys (
		.clk    (clk),
		.sys_rst(sys_rst),
		.key    ({key_mode, key_down, key_up, key_set}),
		.press  (press)
	);

	assign set_p  = press[0];
	assign up_p   = press[1];
	assign down_p = press[2];
	assign mode_p = press[3];

	pio_fault_mem #(
		.DEPTH(`PIO_FAULT_DEPTH),
		.DW   (16)
	) u_faults (
		.clk    (clk),
		.sys_rst(sys_rst),
		.we     (fault_log),
		.wdata  (fault_code),
		.rage   (psel_r <= `PIO_SEL_FAULT_LAST ? psel_r[2:0] : 3'h0),
		.rdata  (fault_rd)
	);

	// APB slave, no wait states, pready high in the first access cycle
	assign acc     = psel & penable & pready;
	assign wr      = acc & pwrite;
	assign rd_stat = acc & ~pwrite & (paddr == `PIO_OFF_ISTAT);

	always_comb begin
		rd_hit = 1'b1;
		rd_nxt = 32'h0000_0000;
		unique case (paddr)
			`PIO_OFF_PSEL:   rd_nxt = {28'h0, psel_r};
			`PIO_OFF_SFUNC:  rd_nxt = {16'h0, sfunc_r};
			`PIO_OFF_FMASK:  rd_nxt = {26'h0, fmask_r};
			`PIO_OFF_JOGSPD: rd_nxt = {16'h0, jog_spd_r};
			`PIO_OFF_STATUS: rd_nxt = {25'h0, jog_rev, jog_fwd, force_r,
				servo_on, view_r};
			`PIO_OFF_DIAG:   rd_nxt = {10'h0, digital_output_lines, 7'h0,
				digital_input_lines};
			`PIO_OFF_ISTAT:  rd_nxt = {28'h0, istat_r};
			`PIO_OFF_IMASK:  rd_nxt = {28'h0, imask_r};
			default:         rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable & ~pready;
			prdata  <= rd_nxt;
			pslverr <= psel & ~penable & ~pready & ~rd_hit;
		end
	end

	// Writable configuration
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			psel_r  <= `PIO_PSEL_RST;
			fmask_r <= 6'h00;
			imask_r <= `PIO_IMASK_RST;
		end else if (wr) begin
			if (paddr == `PIO_OFF_PSEL) begin
				psel_r <= pwdata[3:0];
			end
			if (paddr == `PIO_OFF_FMASK) begin
				fmask_r <= pwdata[5:0];
			end
			if (paddr == `PIO_OFF_IMASK) begin
				imask_r <= pwdata[3:0];
			end
		end
	end

	// Special function parameter and forced output mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sfunc_r <= `PIO_SFUNC_RST;
			force_r <= 1'b0;
		end else if (wr && paddr == `PIO_OFF_SFUNC) begin
			sfunc_r <= pwdata[15:0];
			if (pwdata[15:0] == `PIO_SFUNC_FORCE) begin
				force_r <= 1'b1;
			end else if (pwdata[15:0] == `PIO_SFUNC_NORMAL) begin
				force_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			digital_output_lines <= 6'h00;
		end else begin
			digital_output_lines <= force_r ? fmask_r : do_func;
		end
	end

	// Panel view state
	always_comb begin
		view_nxt = view_r;
		unique case (view_r)
			pio_pkg::PIO_V_IDLE: begin
				if (set_p) begin
					if (psel_r <= `PIO_SEL_FAULT_LAST) begin
						view_nxt = pio_pkg::PIO_V_FAULT;
					end else if (psel_r == `PIO_SEL_JOG) begin
						view_nxt = pio_pkg::PIO_V_JOG_SPD;
					end else if (psel_r == `PIO_SEL_FMASK) begin
						view_nxt = pio_pkg::PIO_V_FMASK;
					end else if (psel_r == `PIO_SEL_DI) begin
						view_nxt = pio_pkg::PIO_V_DI;
					end else if (psel_r == `PIO_SEL_DO) begin
						view_nxt = pio_pkg::PIO_V_DO;
					end
				end
			end
			pio_pkg::PIO_V_JOG_SPD: begin
				if (mode_p) begin
					view_nxt = pio_pkg::PIO_V_IDLE;
				end else if (set_p) begin
					view_nxt = pio_pkg::PIO_V_JOG_RUN;
				end
			end
			default: begin
				if (mode_p) begin
					view_nxt = pio_pkg::PIO_V_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			view_r <= pio_pkg::PIO_V_IDLE;
		end else begin
			view_r <= view_nxt;
		end
	end

	// Jog speed: software write or keys while shown
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			jog_spd_r <= `PIO_JOG_SPD_RST;
		end else if (wr && paddr == `PIO_OFF_JOGSPD) begin
			jog_spd_r <= pwdata[15:0];
		end else if (view_r == pio_pkg::PIO_V_JOG_SPD && !set_p) begin
			if (up_p && !down_p && jog_spd_r < JOG_MAX) begin
				jog_spd_r <= jog_spd_r + 16'h0001;
			end else if (down_p && !up_p && jog_spd_r != 16'h0000) begin
				jog_spd_r <= jog_spd_r - 16'h0001;
			end
		end
	end

	// Jog motion follows held keys, only with servo on
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			jog_fwd   <= 1'b0;
			jog_rev   <= 1'b0;
			jog_speed <= `PIO_JOG_SPD_RST;
		end else begin
			jog_fwd   <= view_r == pio_pkg::PIO_V_JOG_RUN && servo_on
				&& key_up && !key_down;
			jog_rev   <= view_r == pio_pkg::PIO_V_JOG_RUN && servo_on
				&& key_down && !key_up;
			jog_speed <= jog_spd_r;
		end
	end

	// Display composition
	always_comb begin
		hexval = 16'h0000;
		unique case (view_r)
			pio_pkg::PIO_V_FAULT:   hexval = fault_rd;
			pio_pkg::PIO_V_JOG_SPD: hexval = jog_spd_r;
			pio_pkg::PIO_V_FMASK:   hexval = {10'h0, fmask_r};
			pio_pkg::PIO_V_DI:      hexval = {7'h0, digital_input_lines};
			pio_pkg::PIO_V_DO:      hexval = {10'h0, digital_output_lines};
			default:                hexval = 16'h0000;
		endcase
		unique case (view_r)
			pio_pkg::PIO_V_IDLE: begin
				disp_nxt = {5{`PIO_DIG_BLANK}};
			end
			pio_pkg::PIO_V_JOG_RUN: begin
				disp_nxt = {`PIO_DIG_BLANK, `PIO_DIG_BLANK, `PIO_DIG_J,
					`PIO_DIG_O, `PIO_DIG_G};
			end
			default: begin
				disp_nxt = {`PIO_DIG_BLANK, 1'b0, hexval[15:12], 1'b0,
					hexval[11:8], 1'b0, hexval[7:4], 1'b0,
					hexval[3:0]};
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			disp_digits <= {5{`PIO_DIG_BLANK}};
		end else begin
			disp_digits <= disp_nxt;
		end
	end

	// Sticky events, a read clears only the bits it reported, set wins
	assign ev[`PIO_IRQ_FAULT] = fault_log;
	assign ev[`PIO_IRQ_JOG]   = view_r == pio_pkg::PIO_V_JOG_SPD && set_p
		&& !mode_p;
	assign ev[`PIO_IRQ_FON]   = wr && paddr == `PIO_OFF_SFUNC && !force_r
		&& pwdata[15:0] == `PIO_SFUNC_FORCE;
	assign ev[`PIO_IRQ_FOFF]  = wr && paddr == `PIO_OFF_SFUNC && force_r
		&& pwdata[15:0] == `PIO_SFUNC_NORMAL;
	assign istat_nxt = (rd_stat ? istat_r & ~prdata[3:0] : istat_r) | ev;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			istat_r <= 4'h0;
			irq     <= 1'b0;
		end else begin
			istat_r <= istat_nxt;
			irq     <= |(istat_nxt & imask_r);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_fault_select: assert property (
		$rose(view_r == pio_pkg::PIO_V_FAULT)
		|-> $past(psel_r) <= `PIO_SEL_FAULT_LAST && $past(set_p))
		else $error("fault view entered without fault selection");
	a_jog_default: assert property (
		$past(sys_rst) |-> jog_spd_r == `PIO_JOG_SPD_RST)
		else $error("jog speed default wrong after reset");
	a_jog_adjust: assert property (
		view_r == pio_pkg::PIO_V_JOG_SPD && up_p && !down_p && !set_p
		&& !wr && jog_spd_r < JOG_MAX
		|=> jog_spd_r == $past(jog_spd_r) + 16'h0001)
		else $error("jog speed did not step up");
	a_jog_enter: assert property (
		view_r == pio_pkg::PIO_V_JOG_SPD && set_p && !mode_p
		|=> view_r == pio_pkg::PIO_V_JOG_RUN
		##1 disp_digits[14:10] == `PIO_DIG_J)
		else $error("jog mode not entered with indication");
	a_jog_release: assert property (
		!key_up |=> !jog_fwd)
		else $error("forward jog continues after release");
	a_jog_servo: assert property (
		!servo_on |=> !jog_fwd && !jog_rev)
		else $error("jog motion without servo on");
	a_force_enter: assert property (
		wr && paddr == `PIO_OFF_SFUNC && pwdata[15:0] == `PIO_SFUNC_FORCE
		|=> force_r ##1 digital_output_lines == $past(fmask_r))
		else $error("forced output not entered");
	a_force_mask: assert property (
		force_r && $stable(fmask_r) |=> digital_output_lines == $past(fmask_r))
		else $error("outputs do not follow force mask");
	a_force_leave: assert property (
		wr && paddr == `PIO_OFF_SFUNC && pwdata[15:0] == `PIO_SFUNC_NORMAL
		|=> !force_r ##1 digital_output_lines == $past(do_func))
		else $error("normal outputs not restored");
	a_hex_blank: assert property (
		view_r != pio_pkg::PIO_V_JOG_RUN |=> disp_digits[24:20] == `PIO_DIG_BLANK)
		else $error("leftmost digit not blank");
	a_di_show: assert property (
		view_r == pio_pkg::PIO_V_DI && $stable(view_r)
		|=> disp_digits[13:0] == {3'h0, $past(digital_input_lines[8]),
		1'b0, $past(digital_input_lines[7:4]), 1'b0,
		$past(digital_input_lines[3:0])})
		else $error("input diagnosis pattern wrong");
	a_do_show: assert property (
		view_r == pio_pkg::PIO_V_DO
		|=> disp_digits[3:0] == $past(digital_output_lines[3:0]))
		else $error("output diagnosis pattern wrong");
	c_jog_run: cover property (
		view_r == pio_pkg::PIO_V_JOG_RUN && jog_fwd);
	c_force_on: cover property (force_r && digital_output_lines != 6'h00);
	c_fault_view: cover property (view_r == pio_pkg::PIO_V_FAULT);
	c_irq: cover property ($rose(irq));

endmodule : pio_panel_top

`default_nettype wire

// >>> src/pio_params.svh
// Register offsets, reset values, display codes and field positions
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH

`define PIO_OFF_PSEL    8'h00
`define PIO_OFF_SFUNC   8'h04
`define PIO_OFF_FMASK   8'h08
`define PIO_OFF_JOGSPD  8'h0C
`define PIO_OFF_STATUS  8'h10
`define PIO_OFF_DIAG    8'h14
`define PIO_OFF_ISTAT   8'h18
`define PIO_OFF_IMASK   8'h1C

`define PIO_SFUNC_FORCE  16'h0196
`define PIO_SFUNC_NORMAL 16'h0190
`define PIO_SFUNC_RST    16'h0000
`define PIO_JOG_SPD_RST  16'h0014
`define PIO_JOG_SPD_MAX  16'h1388
`define PIO_PSEL_RST     4'h0
`define PIO_IMASK_RST    4'h0

`define PIO_SEL_FAULT_LAST 4'h4
`define PIO_SEL_JOG        4'h5
`define PIO_SEL_FMASK      4'h6
`define PIO_SEL_DI         4'h7
`define PIO_SEL_DO         4'h8

`define PIO_DIG_BLANK   5'h10
`define PIO_DIG_J       5'h11
`define PIO_DIG_O       5'h12
`define PIO_DIG_G       5'h13

`define PIO_IRQ_FAULT   0
`define PIO_IRQ_JOG     1
`define PIO_IRQ_FON     2
`define PIO_IRQ_FOFF    3

`define PIO_FAULT_DEPTH 5

`endif

// >>> src/pio_pkg.sv
// Types shared by the panel block
package pio_pkg;

	typedef enum logic [2:0] {
		PIO_V_IDLE    = 3'h0,
		PIO_V_JOG_SPD = 3'h1,
		PIO_V_JOG_RUN = 3'h3,
		PIO_V_FAULT   = 3'h2,
		PIO_V_FMASK   = 3'h6,
		PIO_V_DI      = 3'h7,
		PIO_V_DO      = 3'h5
	} pio_view_t;

endpackage : pio_pkg

// >>> src/pio_key_edge.sv
// Press detector for the panel keys
`timescale 1ns/1ns
`default_nettype none

module pio_key_edge #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] key,
	output logic      [WIDTH-1:0] press
);

	logic [WIDTH-1:0] prev_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prev_r <= '0;
		end else begin
			prev_r <= key;
		end
	end

	assign press = key & ~prev_r;

endmodule : pio_key_edge

`default_nettype wire

// >>> src/pio_fault_mem.sv
// Fault record store, newest first, registered read data
`timescale 1ns/1ns
`default_nettype none

module pio_fault_mem #(
	parameter int DEPTH = 5,
	parameter int DW    = 16
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic          we,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [2:0]    rage,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] mem [DEPTH];
	logic [2:0]    wptr_r;
	logic [2:0]    ridx;
	int            tmp;

	always_comb begin
		tmp  = 0;
		tmp  = int'(wptr_r) + 2 * DEPTH - 1 - int'(rage);
		ridx = 3'(tmp % DEPTH);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wptr_r <= 3'h0;
		end else if (we) begin
			wptr_r <= (int'(wptr_r) == DEPTH - 1) ? 3'h0 : wptr_r + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[wptr_r] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata <= '0;
		end else begin
			rdata <= mem[ridx];
		end
	end

endmodule : pio_fault_mem

`default_nettype wire

// >>> sim/pio_operator.sv
// Operator keypad model driving the panel keys
`timescale 1ns/1ns
`default_nettype none

module pio_operator (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [3:0] want,
	output logic      [3:0] keys
);
	// Keys change only on clock edges, released during reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			keys <= 4'h0;
		end else begin
			keys <= want;
		end
	end
endmodule : pio_operator

`default_nettype wire

// >>> sim/pio_panel_top_tb_top.sv
// Self-checking bench for the panel block
`timescale 1ns/1ns
`default_nettype none
`include "pio_params.svh"

module pio_panel_top_tb_top;
	typedef struct {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic        err;
	} pio_row_t;
	logic        clk      = 1'h0;
	logic        sys_rst  = 1'h1;
	logic        psel     = 1'h0;
	logic        penable  = 1'h0;
	logic        pwrite   = 1'h0;
	logic [7:0]  paddr    = 8'h00;
	logic [31:0] pwdata   = 32'h0;
	logic [3:0]  want     = 4'h0;
	logic        servo_on = 1'h0;
	logic        fault_log = 1'h0;
	logic [15:0] fault_code = 16'h0;
	logic [8:0]  dil      = 9'h1E1;
	logic [5:0]  do_func  = 6'h2A;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, jog_fwd, jog_rev, irq;
	logic [5:0]  dol;
	logic [15:0] jog_speed;
	logic [24:0] disp;
	logic [3:0]  keys;
	int          fails    = 0;
	int          checked  = 0;
	pio_row_t    rows [12] = '{
		'{1'h0, `PIO_OFF_JOGSPD, 32'h14, 1'h0},
		'{1'h0, `PIO_OFF_PSEL, 32'h0, 1'h0},
		'{1'h0, `PIO_OFF_IMASK, 32'h0, 1'h0},
		'{1'h1, `PIO_OFF_FMASK, 32'h2D, 1'h0},
		'{1'h0, `PIO_OFF_FMASK, 32'h2D, 1'h0},
		'{1'h1, `PIO_OFF_JOGSPD, 32'h30, 1'h0},
		'{1'h0, `PIO_OFF_JOGSPD, 32'h30, 1'h0},
		'{1'h1, `PIO_OFF_JOGSPD, 32'h14, 1'h0},
		'{1'h0, `PIO_OFF_STATUS, 32'h0, 1'h0},
		'{1'h0, `PIO_OFF_DIAG, 32'h002A01E1, 1'h0},
		'{1'h0, 8'h20, 32'h0, 1'h1},
		'{1'h1, 8'h24, 32'h1, 1'h1}
	};

	initial forever #2 clk = ~clk;

	pio_operator u_op (.clk(clk), .sys_rst(sys_rst), .want(want),
		.keys(keys));

	pio_panel_top u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .key_set(keys[0]), .key_up(keys[1]),
		.key_down(keys[2]), .key_mode(keys[3]), .servo_on(servo_on),
		.fault_log(fault_log), .fault_code(fault_code),
		.digital_input_lines(dil), .do_func(do_func),
		.digital_output_lines(dol), .jog_fwd(jog_fwd),
		.jog_rev(jog_rev), .jog_speed(jog_speed), .disp_digits(disp),
		.irq(irq));

	task automatic report_and_stop();
		if (fails == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) begin
			n++;
			if (n > 20) begin
				fails++;
				report_and_stop();
			end
			@(posedge clk);
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic press(input int k);
		@(posedge clk);
		want[k] <= 1'h1;
		repeat (2) @(posedge clk);
		want[k] <= 1'h0;
		repeat (5) @(posedge clk);
		@(negedge clk);
	endtask : press

	task automatic view(input logic [3:0] sel);
		press(3);
		apb(1'h1, `PIO_OFF_PSEL, {28'h0, sel});
		press(0);
	endtask : view

	task automatic jogk(input int k, input logic on, input logic f,
		input logic r);
		@(posedge clk);
		servo_on <= on;
		want[k]  <= 1'h1;
		repeat (4) @(negedge clk);
		chk(jog_fwd, f);
		chk(jog_rev, r);
		@(posedge clk);
		want[k] <= 1'h0;
		repeat (4) @(negedge clk);
		chk({jog_fwd, jog_rev}, 2'h0);
		@(posedge clk);
		servo_on <= 1'h0;
	endtask : jogk

	task automatic log_fault(input logic [15:0] c);
		@(posedge clk);
		fault_code <= c;
		fault_log  <= 1'h1;
		@(posedge clk);
		fault_log  <= 1'h0;
	endtask : log_fault

	function automatic logic [24:0] hexv(input logic [15:0] v);
		return {`PIO_DIG_BLANK, 1'h0, v[15:12], 1'h0, v[11:8],
			1'h0, v[7:4], 1'h0, v[3:0]};
	endfunction : hexv

	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk(disp, {5{`PIO_DIG_BLANK}});
		chk(jog_speed, 16'h0014);
		chk({dol, jog_fwd, jog_rev, irq, pready, pslverr}, 11'h0);
		@(posedge clk);
		sys_rst <= 1'h0;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk(er, rows[i].err);
			if (!rows[i].w) chk(rd, rows[i].d);
		end
		apb(1'h1, `PIO_OFF_IMASK, 32'h4);
		apb(1'h1, `PIO_OFF_SFUNC, 32'h196);
		apb(1'h1, `PIO_OFF_FMASK, 32'h5);
		repeat (2) @(negedge clk);
		chk(irq, 1'h1);
		chk(dol, 6'h05);
		apb(1'h0, `PIO_OFF_ISTAT, 32'h0);
		chk(rd, 32'h4);
		apb(1'h1, `PIO_OFF_FMASK, 32'h2);
		repeat (2) @(negedge clk);
		chk(irq, 1'h0);
		chk(dol, 6'h02);
		apb(1'h1, `PIO_OFF_SFUNC, 32'h190);
		repeat (2) @(negedge clk);
		chk(dol, do_func);
		apb(1'h0, `PIO_OFF_ISTAT, 32'h0);
		chk(rd, 32'h8);
		@(negedge clk);
		chk(irq, 1'h0);
		apb(1'h1, `PIO_OFF_SFUNC, 32'h196);
		@(posedge clk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		repeat (3) @(negedge clk);
		chk(dol, do_func);
		chk(disp, {5{`PIO_DIG_BLANK}});
		chk(jog_speed, 16'h0014);
		view(`PIO_SEL_DO);
		chk(disp, hexv(16'h002A));
		apb(1'h1, `PIO_OFF_FMASK, 32'h2D);
		view(`PIO_SEL_FMASK);
		chk(disp, hexv(16'h002D));
		view(`PIO_SEL_DI);
		chk(disp, hexv(16'h01E1));
		log_fault(16'hABCD);
		log_fault(16'h1234);
		view(4'h0);
		chk(disp, hexv(16'h1234));
		view(4'h1);
		chk(disp, hexv(16'hABCD));
		view(`PIO_SEL_JOG);
		chk(disp, hexv(16'h0014));
		press(1);
		chk(jog_speed, 16'h0015);
		chk(disp, hexv(16'h0015));
		press(2);
		press(2);
		chk(jog_speed, 16'h0013);
		press(0);
		chk(disp, {{2{`PIO_DIG_BLANK}}, `PIO_DIG_J, `PIO_DIG_O,
			`PIO_DIG_G});
		jogk(1, 1'h1, 1'h1, 1'h0);
		jogk(2, 1'h1, 1'h0, 1'h1);
		jogk(1, 1'h0, 1'h0, 1'h0);
		report_and_stop();
	end
endmodule : pio_panel_top_tb_top

`default_nettype wire
